/* File: verilog/vprot_pkg.sv */
// package: register map, field layouts and constants of the voltage protection element
package vprot_pkg;
	localparam logic [3:0] CTRL_ADDR     = 4'h0;
	localparam logic [3:0] RATING_ADDR   = 4'h1;
	localparam logic [3:0] PH_LEVEL_ADDR = 4'h2;
	localparam logic [3:0] PH_TIME_ADDR  = 4'h3;
	localparam logic [3:0] IMIN_ADDR     = 4'h4;
	localparam logic [3:0] G_LEVEL_ADDR  = 4'h5;
	localparam logic [3:0] G_TIME_ADDR   = 4'h6;
	localparam logic [3:0] STATE_ADDR    = 4'h7;
	localparam logic [3:0] IRQ_STAT_ADDR = 4'h8;
	localparam logic [3:0] IRQ_MASK_ADDR = 4'h9;

	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_NS  = 1000000;
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

	// 1/sqrt(3) in Q16, hold limits 0.969 and 1.031 in Q8
	localparam logic [16:0] INV_SQRT3_Q16 = 17'h093CD;
	localparam logic [10:0] OV_HOLD_Q8    = 11'h0F8;
	localparam logic [10:0] UV_HOLD_Q8    = 11'h108;

	localparam logic [31:0] CTRL_RESET   = 32'h0000_3000;
	localparam logic [31:0] RATING_RESET = 32'h0064_0064;
	localparam logic [31:0] LEVEL_RESET  = 32'h00F8_0133;
	localparam logic [31:0] TIME_RESET   = 32'h0064_0064;
	localparam logic [31:0] IMIN_RESET   = 32'h0000_0010;
	localparam logic [3:0]  MASK_RESET   = 4'h0;

	typedef enum logic [1:0] {
		METH_FUND = 2'b00,
		METH_RMS  = 2'b01,
		METH_AVG  = 2'b10
	} method_type;

	typedef enum logic [1:0] {
		PICK_ANY = 2'b00,
		PICK_TWO = 2'b01,
		PICK_ALL = 2'b10
	} pick_rule_type;

	typedef struct packed {
		logic [17:0]   spare;
		logic          fourth_en;
		logic          phase_en;
		logic          superv_only;
		logic          fourth_rms;
		logic          src_calc;
		logic          fourth_under;
		logic          imin_en;
		pick_rule_type rule;
		method_type    method;
		logic          mode_p2p;
		logic          phase_under;
		logic          conn_delta;
	} ctrl_type;

	typedef struct packed {
		logic [15:0] fourth;
		logic [15:0] phase;
	} rating_type;

	typedef struct packed {
		logic [4:0]  spare;
		logic [10:0] ratio;
		logic [15:0] thr;
	} level_type;

	typedef struct packed {
		logic [15:0] imin_delay;
		logic [15:0] trip_delay;
	} time_type;

	typedef struct packed {
		logic [2:0][15:0] v_fund;
		logic [2:0][15:0] v_rms;
		logic [2:0][15:0] v_avg;
		logic [2:0][15:0] cur;
		logic [15:0]      x_fund;
		logic [15:0]      x_rms;
		logic [15:0]      x_calc;
	} meas_type;
endpackage

/* File: verilog/voltage_protection_element.sv */
// module: phase and fourth-input voltage protection with register port
`timescale 1ns/100ps
module voltage_protection_element #(
	parameter int TICK_CYCLES = vprot_pkg::TICK_CYCLES
) (
	input  wire logic               core_clk,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire logic [3:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr_en,
	input  wire logic               rd_en,
	output logic [31:0]             rdata,
	input  wire vprot_pkg::meas_type meas,
	input  wire logic               trip_block,
	output logic [2:0]              alarm_phase,
	output logic [2:0]              trip_phase,
	output logic                    phase_alarm,
	output logic                    phase_trip,
	output logic                    fourth_alarm,
	output logic                    fourth_trip,
	output logic                    fourth_trip_command,
	output logic                    general_alarm,
	output logic                    general_trip,
	output logic                    irq
);
	vprot_pkg::ctrl_type   ctrl;
	vprot_pkg::rating_type rating;
	vprot_pkg::level_type  level [2];
	vprot_pkg::time_type   times [2];
	logic [15:0]           imin_thr, imin_cnt;
	logic [3:0]            irq_stat, irq_mask, next_irq_stat, irq_clr;
	logic [3:0]            chan_pick;
	logic [16:0]           tick_cnt;
	logic                  tick, imin_active, all_low, imin_block, g_valid;
	logic [15:0]           vn [2], val [4], el_cnt [2];
	logic [23:0]           lvl [2], rel [2], hold [2];
	logic                  under [2], en [2];
	logic [1:0]            pick, blk, el_alarm, el_trip, alarm_d, trip_d;
	logic [1:0]            n_pick;
	logic [32:0]           pg_prod;

	// scale a level by a Q8 factor, saturating
	function automatic logic [23:0] mul_q8(input logic [23:0] a,
		input logic [15:0] f);
		logic [39:0] p;
		p = {16'h0000, a} * {24'h00_0000, f};
		mul_q8 = (p[39:32] != 8'h00) ? 24'hFF_FFFF : p[31:8];
	endfunction

	// register writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl     <= vprot_pkg::CTRL_RESET;
			rating   <= vprot_pkg::RATING_RESET;
			level[0] <= vprot_pkg::LEVEL_RESET;
			level[1] <= vprot_pkg::LEVEL_RESET;
			times[0] <= vprot_pkg::TIME_RESET;
			times[1] <= vprot_pkg::TIME_RESET;
			imin_thr <= vprot_pkg::IMIN_RESET[15:0];
			irq_mask <= vprot_pkg::MASK_RESET;
		end else if (ce && wr_en) begin
			unique case (addr)
				vprot_pkg::CTRL_ADDR:     ctrl <= {18'h0_0000, wdata[13:0]};
				vprot_pkg::RATING_ADDR:   rating <= wdata;
				vprot_pkg::PH_LEVEL_ADDR: level[0] <= {5'h00, wdata[26:0]};
				vprot_pkg::G_LEVEL_ADDR:  level[1] <= {5'h00, wdata[26:0]};
				vprot_pkg::PH_TIME_ADDR:  times[0] <= wdata;
				vprot_pkg::G_TIME_ADDR:   times[1] <= {16'h0000, wdata[15:0]};
				vprot_pkg::IMIN_ADDR:     imin_thr <= wdata[15:0];
				vprot_pkg::IRQ_MASK_ADDR: irq_mask <= wdata[3:0];
				default: ;
			endcase
		end
	end

	// read port: data stand only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rdata <= 32'h0000_0000;
		end else if (ce) begin
			rdata <= 32'h0000_0000;
			if (rd_en) begin
				unique case (addr)
					vprot_pkg::CTRL_ADDR:     rdata <= ctrl;
					vprot_pkg::RATING_ADDR:   rdata <= rating;
					vprot_pkg::PH_LEVEL_ADDR: rdata <= level[0];
					vprot_pkg::G_LEVEL_ADDR:  rdata <= level[1];
					vprot_pkg::PH_TIME_ADDR:  rdata <= times[0];
					vprot_pkg::G_TIME_ADDR:   rdata <= times[1];
					vprot_pkg::IMIN_ADDR:     rdata <= {16'h0000, imin_thr};
					vprot_pkg::STATE_ADDR:    rdata <= {23'h00_0000,
						imin_block, el_trip, el_alarm, chan_pick};
					vprot_pkg::IRQ_STAT_ADDR: rdata <= {28'h000_0000, irq_stat};
					vprot_pkg::IRQ_MASK_ADDR: rdata <= {28'h000_0000, irq_mask};
					default:                  rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// millisecond tick for all delays; shorten TICK_CYCLES in simulation
	always_ff @(posedge core_clk) begin
		if (srst) begin
			tick_cnt <= 17'h0_0000;
			tick     <= 1'b0;
		end else if (ce) begin
			tick     <= (tick_cnt == 17'(TICK_CYCLES - 1));
			tick_cnt <= (tick_cnt == 17'(TICK_CYCLES - 1)) ? 17'h0_0000
				: tick_cnt + 17'h0_0001;
		end
	end

	always_comb begin
		pg_prod = {17'h0_0000, rating.phase} * {16'h0000, vprot_pkg::INV_SQRT3_Q16};
		vn[0] = (ctrl.conn_delta || ctrl.mode_p2p) ? rating.phase
			: pg_prod[31:16];
		vn[1] = ctrl.src_calc ? rating.phase : rating.fourth;
		g_valid = !(ctrl.src_calc && ctrl.conn_delta);
		under[0] = ctrl.phase_under;
		under[1] = ctrl.fourth_under;
		en[0] = ctrl.phase_en;
		en[1] = ctrl.fourth_en && g_valid;
		for (int p = 0; p < 3; p++) begin
			unique case (ctrl.method)
				vprot_pkg::METH_RMS: val[p] = meas.v_rms[p];
				vprot_pkg::METH_AVG: val[p] = meas.v_avg[p];
				default:             val[p] = meas.v_fund[p];
			endcase
		end
		if (ctrl.src_calc)
			val[3] = meas.x_calc;
		else
			val[3] = ctrl.fourth_rms ? meas.x_rms : meas.x_fund;
		for (int e = 0; e < 2; e++) begin
			lvl[e] = mul_q8({8'h00, vn[e]}, level[e].thr);
			rel[e] = mul_q8(lvl[e], {5'h00, level[e].ratio});
			hold[e] = mul_q8(lvl[e], {5'h00, under[e]
				? vprot_pkg::UV_HOLD_Q8 : vprot_pkg::OV_HOLD_Q8});
			if (under[e] && rel[e] < hold[e])
				rel[e] = hold[e];
			if (!under[e] && rel[e] > hold[e])
				rel[e] = hold[e];
		end
	end

	// per-channel pickup with hysteresis; channel 3 is the fourth input
	generate
		for (genvar c = 0; c < 4; c++) begin : g_chan
			localparam int E = (c == 3) ? 1 : 0;
			always_ff @(posedge core_clk) begin
				if (srst) begin
					chan_pick[c] <= 1'b0;
				end else if (ce) begin
					if (!en[E])
						chan_pick[c] <= 1'b0;
					else if (under[E])
						chan_pick[c] <= ({8'h00, val[c]} < lvl[E]) ||
							(chan_pick[c] && {8'h00, val[c]} < rel[E]);
					else
						chan_pick[c] <= ({8'h00, val[c]} > lvl[E]) ||
							(chan_pick[c] && {8'h00, val[c]} >= rel[E]);
				end
			end
		end
	endgenerate

	always_comb begin
		n_pick = 2'(chan_pick[0]) + 2'(chan_pick[1]) + 2'(chan_pick[2]);
		unique case (ctrl.rule)
			vprot_pkg::PICK_TWO: pick[0] = (n_pick >= 2'd2);
			vprot_pkg::PICK_ALL: pick[0] = (n_pick == 2'd3);
			default:             pick[0] = (n_pick != 2'd0);
		endcase
		pick[1] = chan_pick[3];
		// only for undervoltage with check enabled
		imin_active = ctrl.phase_under && ctrl.imin_en;
		all_low = (meas.cur[0] < imin_thr) && (meas.cur[1] < imin_thr) &&
			(meas.cur[2] < imin_thr);
		blk = {1'b0, imin_block};
	end

	// dead currents mean an open breaker, so phase undervoltage must stay quiet
	always_ff @(posedge core_clk) begin
		if (srst) begin
			imin_block <= 1'b0;
			imin_cnt   <= 16'h0000;
		end else if (ce) begin
			if (!imin_active) begin
				imin_block <= 1'b0;
				imin_cnt   <= 16'h0000;
			end else if (all_low) begin
				imin_block <= 1'b1;
				imin_cnt   <= 16'h0000;
			end else if (imin_block) begin
				if (imin_cnt >= times[0].imin_delay)
					imin_block <= 1'b0;
				else if (tick)
					imin_cnt <= imin_cnt + 16'h0001;
			end
		end
	end

	// trip delay per element
	generate
		for (genvar e = 0; e < 2; e++) begin : g_elem
			always_ff @(posedge core_clk) begin
				if (srst) begin
					el_alarm[e] <= 1'b0;
					el_trip[e]  <= 1'b0;
					el_cnt[e]   <= 16'h0000;
				end else if (ce) begin
					if (!pick[e] || blk[e]) begin
						el_alarm[e] <= 1'b0;
						el_trip[e]  <= 1'b0;
						el_cnt[e]   <= 16'h0000;
					end else begin
						el_alarm[e] <= 1'b1;
						if (el_cnt[e] >= times[e].trip_delay)
							el_trip[e] <= 1'b1;
						else if (tick)
							el_cnt[e] <= el_cnt[e] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (srst) begin
			alarm_phase         <= 3'h0;
			trip_phase          <= 3'h0;
			phase_alarm         <= 1'b0;
			phase_trip          <= 1'b0;
			fourth_alarm        <= 1'b0;
			fourth_trip         <= 1'b0;
			fourth_trip_command <= 1'b0;
			general_alarm       <= 1'b0;
			general_trip        <= 1'b0;
			alarm_d             <= 2'h0;
			trip_d              <= 2'h0;
		end else if (ce) begin
			alarm_phase  <= chan_pick[2:0] & {3{el_alarm[0]}};
			trip_phase   <= chan_pick[2:0] & {3{el_trip[0]}};
			phase_alarm  <= el_alarm[0];
			phase_trip   <= el_trip[0];
			fourth_alarm <= el_alarm[1];
			fourth_trip  <= el_trip[1];
			// supervision only or external trip_block: no command
			fourth_trip_command <= el_trip[1] && !ctrl.superv_only &&
				!trip_block;
			general_alarm <= el_alarm[0] || el_alarm[1];
			general_trip  <= el_trip[0] || el_trip[1];
			alarm_d <= el_alarm;
			trip_d  <= el_trip;
		end
	end

	// sticky events; a new event in the clearing cycle wins
	always_comb begin
		irq_clr = (wr_en && addr == vprot_pkg::IRQ_STAT_ADDR) ? wdata[3:0]
			: 4'h0;
		next_irq_stat = (irq_stat & ~irq_clr) |
			{el_trip[1] & ~trip_d[1], el_alarm[1] & ~alarm_d[1],
			 el_trip[0] & ~trip_d[0], el_alarm[0] & ~alarm_d[0]};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_stat <= 4'h0;
			irq      <= 1'b0;
		end else if (ce) begin
			irq_stat <= next_irq_stat;
			irq      <= |(irq_stat & irq_mask);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_method_avg: assert property (
		ctrl.method == vprot_pkg::METH_AVG |-> val[1] == meas.v_avg[1])
		else $error("average method not selected");
	a_vn_star_pg: assert property (
		!ctrl.conn_delta && !ctrl.mode_p2p && rating.phase > 16'h000F
		|-> vn[0] < rating.phase && vn[0] > (rating.phase >> 1))
		else $error("star reference not rating over root three");
	a_vn_delta_force: assert property (
		ctrl.conn_delta |-> vn[0] == rating.phase)
		else $error("delta wiring did not force phase rating");
	a_imin_under_only: assert property (
		ce && !imin_active |=> !imin_block)
		else $error("current block without undervoltage check");
	a_imin_block_set: assert property (
		ce && imin_active && all_low |=> imin_block ##1 !el_alarm[0])
		else $error("dead currents did not block");
	a_imin_hold_delay: assert property (
		ce && imin_active && imin_block && !all_low &&
		imin_cnt < times[0].imin_delay |=> imin_block)
		else $error("undervoltage re-enabled before delay");
	a_pick_all: assert property (
		ctrl.rule == vprot_pkg::PICK_ALL && chan_pick[2:0] != 3'h7
		|-> !pick[0])
		else $error("all-phase pickup on fewer phases");
	a_over_hold: assert property (
		ce && en[0] && !under[0] && chan_pick[0] &&
		{8'h00, val[0]} >= mul_q8(lvl[0], {5'h00, vprot_pkg::OV_HOLD_Q8})
		|=> chan_pick[0])
		else $error("overvoltage released above hold band");
	a_under_hold: assert property (
		ce && en[0] && under[0] && chan_pick[0] &&
		{8'h00, val[0]} < mul_q8(lvl[0], {5'h00, vprot_pkg::UV_HOLD_Q8})
		|=> chan_pick[0])
		else $error("undervoltage released below hold band");
	a_superv_no_cmd: assert property (
		ce && ctrl.superv_only |=> !fourth_trip_command)
		else $error("trip command in supervision-only mode");
	a_calc_unavail: assert property (
		ce && ctrl.src_calc && ctrl.conn_delta |=> !chan_pick[3])
		else $error("calculated residual used with delta wiring");
	a_general_trip: assert property (
		ce && el_trip[1] |=> general_trip)
		else $error("fourth trip missing from general trip");
	a_trip_needs_alarm: assert property (
		ce && el_trip[0] |=> $past(el_alarm[0]) && el_alarm[0] ||
		!el_trip[0])
		else $error("trip without preceding alarm");
	a_release_clears: assert property (
		ce && !pick[0] |=> !el_alarm[0] && !el_trip[0] && el_cnt[0] == 16'h0000)
		else $error("release did not clear element");

	c_phase_trip: cover property (ce && el_trip[0] && !$past(el_trip[0]));
	c_imin_reenable: cover property ($fell(imin_block) && imin_active);
	c_fourth_cmd: cover property (fourth_trip_command);
	c_irq_clear_set: cover property (irq_clr != 4'h0 && next_irq_stat != 4'h0);
endmodule // voltage_protection_element

/* File: dv/front_end_model.sv */
// front end model: turns commanded magnitudes into a measurement bundle
`timescale 1ns/100ps
module front_end_model (
	input  wire logic                  core_clk,
	input  wire logic [2:0][15:0]      v,
	input  wire logic [2:0][15:0]      cur,
	input  wire logic [15:0]           x,
	input  wire logic [15:0]           other,
	input  wire vprot_pkg::method_type meth,
	input  wire logic                  x_rms_sel,
	output vprot_pkg::meas_type        meas
);
	// unselected methods carry another value, so a wrong pick shows up
	always_ff @(posedge core_clk) begin
		meas.v_fund <= (meth == vprot_pkg::METH_FUND) ? v : {3{other}};
		meas.v_rms  <= (meth == vprot_pkg::METH_RMS) ? v : {3{other}};
		meas.v_avg  <= (meth == vprot_pkg::METH_AVG) ? v : {3{other}};
		meas.cur    <= cur;
		meas.x_fund <= x_rms_sel ? other : x;
		meas.x_rms  <= x_rms_sel ? x : other;
		// residual from the phases is modelled as the same value
		meas.x_calc <= x;
	end
endmodule // front_end_model

/* File: dv/testbench.sv */
// testbench: register port, phase element and fourth element scenarios
`timescale 1ns/100ps
module testbench;
	localparam int TICKS = 4;
	localparam int LIMIT = 6000;
	logic                  core_clk = 1'b0;
	logic                  srst = 1'b1;
	logic                  ce = 1'b1;
	logic [3:0]            addr = 4'h0;
	logic [31:0]           wdata = 32'h0;
	logic                  wr_en = 1'b0;
	logic                  rd_en = 1'b0;
	logic [31:0]           rdata;
	vprot_pkg::meas_type   meas;
	logic                  trip_block = 1'b0;
	logic                  phase_alarm, phase_trip, fourth_alarm;
	logic                  fourth_trip, fourth_trip_command;
	logic                  general_alarm, general_trip, irq;
	logic [2:0]            alarm_phase, trip_phase;
	logic [2:0][15:0]      v = {3{16'h0032}};
	logic [2:0][15:0]      cur = {3{16'h0064}};
	logic [15:0]           x = 16'h0032;
	logic [15:0]           other = 16'h0032;
	vprot_pkg::method_type meth = vprot_pkg::METH_FUND;
	logic                  x_rms_sel = 1'b0;
	logic [31:0]           seed = 32'hE26B7228;
	logic [31:0]           word_q[$];
	logic [13:0]           flag_q[$];
	logic                  look = 1'b0;
	logic                  rd_seen = 1'b0;
	int                    fail_count = 0;
	int                    tests_run = 0;
	int                    cyc = 0;
	vprot_pkg::ctrl_type   c;
	logic [15:0]           pk [3] = '{16'd120, 16'd120, 16'd80};
	logic [15:0]           hd [3] = '{16'd90, 16'd97, 16'd102};
	logic [15:0]           dr [3] = '{16'd86, 16'd95, 16'd104};

	always #5 core_clk = ~core_clk;

	voltage_protection_element #(.TICK_CYCLES(TICKS)) u_dut (
		.core_clk(core_clk), .srst(srst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.meas(meas), .trip_block(trip_block), .alarm_phase(alarm_phase),
		.trip_phase(trip_phase), .phase_alarm(phase_alarm),
		.phase_trip(phase_trip),
		.fourth_alarm(fourth_alarm), .fourth_trip(fourth_trip),
		.fourth_trip_command(fourth_trip_command),
		.general_alarm(general_alarm), .general_trip(general_trip),
		.irq(irq));

	front_end_model u_fe (
		.core_clk(core_clk), .v(v), .cur(cur), .x(x), .other(other),
		.meth(meth), .x_rms_sel(x_rms_sel), .meas(meas));

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	// bits: phase alarm, phase trip, fourth alarm, trip, command, irq
	function automatic logic [7:0] flags_of(input logic [5:0] b);
		return {b[5:1], b[5] | b[3], b[4] | b[2], b[0]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// flags: per-phase alarm and trip, then the eight element flags
	task automatic chk_flags(input logic [13:0] got, input logic [13:0] e);
		chk({18'h0, got}, {18'h0, e});
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		wr_en <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge core_clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		word_q.push_back(e);
		@(posedge core_clk);
		rd_en <= 1'b1;
		addr  <= a;
		@(posedge core_clk);
		rd_en <= 1'b0;
	endtask

	// waits out the measure-to-output latency before looking
	task automatic see(input logic [5:0] e, input logic [2:0] ph = 3'h7);
		repeat (6) @(posedge core_clk);
		flag_q.push_back({ph & {3{e[5]}}, ph & {3{e[4]}}, flags_of(e)});
		look <= 1'b1;
		@(posedge core_clk);
		look <= 1'b0;
	endtask

	task automatic g(input logic [31:0] cw, input logic b, input logic s,
			input logic [15:0] xv, input logic [5:0] e);
		trip_block <= b;
		x_rms_sel  <= s;
		x          <= xv;
		wr(vprot_pkg::CTRL_ADDR, cw);
		see(e);
	endtask

	// results are compared in the cycle where they stand
	always @(posedge core_clk) begin
		if (look)
			chk_flags({alarm_phase, trip_phase, phase_alarm, phase_trip,
				fourth_alarm, fourth_trip, fourth_trip_command,
				general_alarm, general_trip, irq},
				flag_q.pop_front());
		if (rd_seen)
			chk(rdata, word_q.pop_front());
		rd_seen <= rd_en;
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fail_count++;
			give_verdict();
		end
	end

	initial begin
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		rd(vprot_pkg::CTRL_ADDR, vprot_pkg::CTRL_RESET);
		rd(vprot_pkg::RATING_ADDR, vprot_pkg::RATING_RESET);
		rd(vprot_pkg::PH_LEVEL_ADDR, vprot_pkg::LEVEL_RESET);
		rd(vprot_pkg::PH_TIME_ADDR, vprot_pkg::TIME_RESET);
		rd(vprot_pkg::IMIN_ADDR, vprot_pkg::IMIN_RESET);
		rd(vprot_pkg::IRQ_MASK_ADDR, {28'h0, vprot_pkg::MASK_RESET});
		rd(4'hF, 32'h0);
		wr(vprot_pkg::RATING_ADDR, 32'h00C8_0064);
		wr(vprot_pkg::PH_LEVEL_ADDR, 32'h0100_0100);
		wr(vprot_pkg::G_LEVEL_ADDR, 32'h0100_0100);
		wr(vprot_pkg::PH_TIME_ADDR, 32'h0006_0064);
		wr(vprot_pkg::G_TIME_ADDR, 32'h0000_0000);
		rd(vprot_pkg::RATING_ADDR, 32'h00C8_0064);
		c = '0;
		c.phase_en = 1'b1;
		c.conn_delta = 1'b1;
		for (int r = 0; r < 3; r++) begin
			for (int n = 1; n < 4; n++) begin
				c.rule = vprot_pkg::pick_rule_type'(r);
				for (int i = 0; i < 3; i++)
					v[i] <= (i < n) ? 16'(120 + rnd() % 8) : 16'(50 + rnd() % 40);
				wr(vprot_pkg::CTRL_ADDR, c);
				see({r == 0 || (r == 1 && n > 1) || n == 3, 5'h0},
					3'((1 << n) - 1));
			end
		end
		c.rule = vprot_pkg::PICK_ANY;
		v <= {3{16'd120}};
		for (int m = 0; m < 3; m++) begin
			meth <= vprot_pkg::method_type'(m);
			c.method = vprot_pkg::method_type'(m);
			wr(vprot_pkg::CTRL_ADDR, c);
			see(6'b100000);
			c.method = vprot_pkg::method_type'((m + 1) % 3);
			wr(vprot_pkg::CTRL_ADDR, c);
			see(6'b000000);
		end
		meth <= vprot_pkg::METH_FUND;
		c.method = vprot_pkg::METH_FUND;
		for (int k = 0; k < 3; k++) begin
			c.phase_under = (k == 2);
			wr(vprot_pkg::CTRL_ADDR, c);
			wr(vprot_pkg::PH_LEVEL_ADDR, {5'h0, k ? 11'h100 : 11'h0E0, 16'h0100});
			v <= {3{pk[k]}};
			see(6'b100000);
			v <= {3{hd[k]}};
			see(6'b100000);
			v <= {3{dr[k]}};
			see(6'b000000);
		end
		c.phase_under = 1'b0;
		v <= {3{16'd60}};
		for (int k = 0; k < 3; k++) begin
			c.conn_delta = (k == 2);
			c.mode_p2p = (k == 1);
			wr(vprot_pkg::CTRL_ADDR, c);
			see({k == 0, 5'h0});
		end
		wr(vprot_pkg::PH_TIME_ADDR, 32'h0006_0006);
		v <= {3{16'd120}};
		see(6'b100000);
		repeat (30) @(posedge core_clk);
		see(6'b110000);
		v <= {3{16'd50}};
		see(6'b000000);
		v <= {3{16'd120}};
		see(6'b100000);
		v <= {3{16'd50}};
		wr(vprot_pkg::PH_TIME_ADDR, 32'h0006_0064);
		cur <= {3{16'(rnd() % 16)}};
		c.phase_under = 1'b1;
		c.imin_en = 1'b1;
		wr(vprot_pkg::CTRL_ADDR, c);
		see(6'b000000);
		cur[1] <= 16'd100;
		see(6'b000000);
		repeat (30) @(posedge core_clk);
		see(6'b100000);
		cur[1] <= 16'd3;
		c.imin_en = 1'b0;
		wr(vprot_pkg::CTRL_ADDR, c);
		see(6'b100000);
		c.phase_under = 1'b0;
		c.imin_en = 1'b1;
		v <= {3{16'd120}};
		wr(vprot_pkg::CTRL_ADDR, c);
		see(6'b100000);
		v <= {3{16'd50}};
		cur <= {3{16'd100}};
		g(32'h0000_2000, 1'b0, 1'b0, 16'd210, 6'b001110);
		g(32'h0000_2000, 1'b1, 1'b0, 16'd210, 6'b001100);
		g(32'h0000_2800, 1'b1, 1'b0, 16'd210, 6'b001100);
		g(32'h0000_2800, 1'b0, 1'b0, 16'd210, 6'b001100);
		g(32'h0000_2400, 1'b0, 1'b0, 16'd210, 6'b000000);
		g(32'h0000_2400, 1'b0, 1'b1, 16'd210, 6'b001110);
		g(32'h0000_2200, 1'b0, 1'b0, 16'd150, 6'b001110);
		g(32'h0000_2201, 1'b0, 1'b0, 16'd150, 6'b000000);
		g(32'h0000_2000, 1'b0, 1'b0, 16'd150, 6'b000000);
		g(32'h0000_2100, 1'b0, 1'b0, 16'd150, 6'b001110);
		g(32'h0000_2100, 1'b0, 1'b0, 16'd210, 6'b000000);
		wr(vprot_pkg::CTRL_ADDR, 32'h0000_1001);
		wr(vprot_pkg::IRQ_STAT_ADDR, 32'h0000_000F);
		rd(vprot_pkg::IRQ_STAT_ADDR, 32'h0);
		v <= {3{16'd120}};
		see(6'b100000);
		rd(vprot_pkg::STATE_ADDR, 32'h0000_0017);
		rd(vprot_pkg::IRQ_STAT_ADDR, 32'h1);
		wr(vprot_pkg::IRQ_MASK_ADDR, 32'h1);
		see(6'b100001);
		wr(vprot_pkg::IRQ_STAT_ADDR, 32'h1);
		see(6'b100000);
		// clock enable low must freeze every flag
		ce <= 1'b0;
		v  <= {3{16'd50}};
		see(6'b100000);
		ce <= 1'b1;
		see(6'b000000);
		rd(vprot_pkg::IRQ_STAT_ADDR, 32'h0);
		repeat (3) @(posedge core_clk);
		give_verdict();
	end
endmodule // testbench
